// File: flrc_buf.sv
module flrc_buf #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic         head_v_q;
  logic [W-1:0] head_q;
  logic         tail_v_q;
  logic [W-1:0] tail_q;
  logic         pop;
  logic         push;

  // head register drives the output directly, tail absorbs a stall
  assign in_ready  = !tail_v_q;
  assign push      = in_valid && in_ready;
  assign pop       = head_v_q && out_ready;
  assign out_valid = head_v_q;
  assign out_data  = head_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_q   <= '0;
      tail_q   <= '0;
    end
    else
    begin
      if (pop || !head_v_q)
      begin
        // refill head from tail first so order is kept
        if (tail_v_q)
        begin
          head_q   <= tail_q;
          head_v_q <= 1'b1;
          tail_v_q <= push;
          tail_q   <= in_data;
        end
        else
        begin
          head_q   <= in_data;
          head_v_q <= push;
        end
      end
      else if (push)
      begin
        tail_q   <= in_data;
        tail_v_q <= 1'b1;
      end
    end
  end
endmodule

// File: flrc_host_model.sv
module flrc_host_model (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // record stream
  input wire logic       rec_valid,
  output logic           rec_ready,
  input wire logic [7:0] rec_data,
  input wire logic       rec_last,
  input wire logic       rec_to_store,
  // bench control and capture
  input wire logic       slow,
  input wire logic       flush,
  output logic [7:0]     got [0:255],
  output int             got_n,
  output logic           got_done,
  output logic           got_store
);
  logic [1:0] pace_q;
  // a slow host takes one byte in four, so the two-entry buffer fills up
  always_ff @(posedge clock)
  begin
    pace_q    <= rst ? 2'h0 : pace_q + 2'h1;
    rec_ready <= !rst && (!slow || pace_q == 2'h3);
  end
  // bytes past a closing beat are not kept until the bench flushes
  always_ff @(posedge clock)
  begin
    if (rst || flush)
    begin
      got_n    <= 0;
      got_done <= 1'b0;
    end
    else if (rec_valid && rec_ready && !got_done)
    begin
      got[got_n[7:0]] <= rec_data;
      got_n           <= got_n + 1;
      got_done        <= rec_last;
      got_store       <= rec_to_store;
    end
  end
endmodule

// File: flrc_pkg.sv
package flrc_pkg;
  // record geometry
  localparam int unsigned REC_LEN     = 147;
  localparam int unsigned PAGE_BASE   = 27;
  localparam int unsigned PAGE_LEN    = 20;
  localparam int unsigned NUM_PAGES   = 6;
  // header byte positions (16-bit fields: upper byte, lower byte is the next one; time runs LSB first)
  localparam int unsigned B_CODE      = 0;
  localparam int unsigned B_TIME      = 1;
  localparam int unsigned B_PK_ICHAN  = 13;
  localparam int unsigned B_PK_VIN    = 15;
  localparam int unsigned B_TEXT      = 17;
  localparam int unsigned B_TINT      = 21;
  localparam int unsigned B_PK_TEXT   = 23;
  // byte offsets within one event page
  localparam int unsigned P_VOUT      = 0;
  localparam int unsigned P_IOUT      = 4;
  localparam int unsigned P_ICHAN     = 6;
  localparam int unsigned P_VIN       = 8;
  localparam int unsigned P_IIN       = 10;
  localparam int unsigned P_SVOUT     = 12;
  // multiplexer steps; the pass ends at LAST_STEP
  localparam logic [4:0] LAST_STEP    = 5'h19;
  localparam logic [4:0] S_VOUT       = 5'h00;
  localparam logic [4:0] S_IOUT       = 5'h02;
  localparam logic [4:0] S_ICHAN      = 5'h04;
  localparam logic [4:0] S_VIN        = 5'h06;
  localparam logic [4:0] S_IIN        = 5'h08;
  localparam logic [4:0] S_SVOUT      = 5'h0A;
  localparam logic [4:0] S_TEXT       = 5'h0C;
  localparam logic [4:0] S_TINT       = 5'h0E;
  // log source codes
  localparam logic [7:0] SRC_FORCED   = 8'hFF;
  localparam logic [7:0] SRC_TON      = 8'h00;
  localparam logic [7:0] SRC_VOUT_OV  = 8'h01;
  localparam logic [7:0] SRC_VOUT_UV  = 8'h02;
  localparam logic [7:0] SRC_IOUT_OC  = 8'h03;
  localparam logic [7:0] SRC_OT       = 8'h05;
  localparam logic [7:0] SRC_UT       = 8'h06;
  localparam logic [7:0] SRC_VIN_OV   = 8'h07;
  localparam logic [7:0] SRC_T2_OT    = 8'h0A;
  // time counter tick and read length bytes
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned TICK_NS     = 200000;
  localparam int unsigned TICK_CYC    = TICK_NS / CLK_NS;
  localparam logic [7:0] EMPTY_LEN    = 8'h00;
  localparam logic [7:0] FULL_LEN     = 8'h93;
  // capture sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PASS = 4'b0010,
    ST_SAVE = 4'b0100,
    ST_READ = 4'b1000
  } flrc_state_t;
endpackage

// File: flrc_top.sv
// Function
// - peak channel input current at bytes 13-14
// - peak input voltage at bytes 15-16
// - last-event external temperature at bytes 17-18
// - last-event die temperature at bytes 21-22
// - peak external temperature at bytes 23-24
// - newest page is one full multiplexer pass
// - finish pass through step 25 first
// - then write header and six pages
// - newest page at byte 27, fixed layout
// - read returns length 147 then 147 bytes, or length zero
// - byte 0 holds the log source code
// - bytes 1-6 hold 200us time, LSB first
module flrc_top #(
  parameter int NP = flrc_pkg::NUM_PAGES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // adc results
  input  wire logic       adc_valid,
  input  wire logic [4:0] adc_step,
  input  wire logic [15:0] adc_value,
  // events and commands
  input  wire logic       fault_pulse,
  input  wire logic [7:0] fault_code,
  input  wire logic       forced_record_store_command,
  input  wire logic       peak_clear_command,
  input  wire logic       record_clear,
  input  wire logic       fault_record_read_command,
  // record byte stream
  output logic            rec_valid,
  input  wire logic       rec_ready,
  output logic [7:0]      rec_data,
  output logic            rec_last,
  output logic            rec_to_store,
  // status
  output logic            busy_q,
  output logic            log_present_q
);
  flrc_pkg::flrc_state_t state_q;
  logic [7:0]  code_q;
  logic [47:0] time_q;
  logic [47:0] snap_time_q;
  logic [11:0] tick_q;
  logic [15:0] pk_ichan_q, pk_vin_q, pk_text_q;
  logic [15:0] h_pk_ichan_q, h_pk_vin_q, h_pk_text_q, h_text_q, h_tint_q;
  logic [15:0] c_vout_q, c_iout_q, c_ichan_q, c_vin_q, c_iin_q, c_text_q, c_tint_q;
  logic [7:0]  c_svout_q;
  logic [15:0] p_vout_q [NP];
  logic [15:0] p_iout_q [NP];
  logic [15:0] p_ichan_q [NP];
  logic [15:0] p_vin_q [NP];
  logic [15:0] p_iin_q [NP];
  logic [7:0]  p_svout_q [NP];
  logic [7:0]  idx_q;
  logic [7:0]  byte_d;
  logic [7:0]  send_d;
  logic        send_last;
  logic        buf_ready;
  logic        emit;
  logic        pass_end;
  logic        new_fault;
  logic        freeze;
  logic        len_slot;
  logic        len_sent_q;

  // linear-11 value scaled to a common integer so peaks compare correctly
  function automatic logic signed [47:0] lin11_val(input logic [15:0] x);
    logic signed [47:0] m;
    logic signed [5:0]  e;
    m = 48'(signed'(x[10:0]));
    e = 6'(signed'(x[15:11])) + 6'sd16;
    lin11_val = m <<< e;
  endfunction

  // upper byte of a field at the lower position
  function automatic logic [7:0] pick(input logic [15:0] v, input logic lo);
    pick = lo ? v[7:0] : v[15:8];
  endfunction

  assign pass_end  = adc_valid && (adc_step == flrc_pkg::LAST_STEP);
  assign new_fault = (fault_pulse && !log_present_q) || forced_record_store_command;
  assign emit      = buf_ready && (state_q == flrc_pkg::ST_SAVE || state_q == flrc_pkg::ST_READ);
  assign freeze    = log_present_q && state_q != flrc_pkg::ST_PASS;
  assign len_slot  = state_q == flrc_pkg::ST_READ && log_present_q && !len_sent_q;

  // free-running time since reset, one count per 200us
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tick_q <= '0;
      time_q <= '0;
    end
    else if (tick_q == 12'(flrc_pkg::TICK_CYC - 1))
    begin
      tick_q <= '0;
      time_q <= time_q + 48'h1;
    end
    else
    begin
      tick_q <= tick_q + 12'h1;
    end
  end

  // peaks since the last clear; a sample in the clear cycle is dropped
  always_ff @(posedge clock)
  begin
    if (rst || peak_clear_command)
    begin
      pk_ichan_q <= 16'h8000;
      pk_vin_q   <= 16'h8000;
      pk_text_q  <= 16'h8000;
    end
    else if (adc_valid)
    begin
      if (adc_step == flrc_pkg::S_ICHAN && lin11_val(adc_value) > lin11_val(pk_ichan_q))
        pk_ichan_q <= adc_value;
      if (adc_step == flrc_pkg::S_VIN && lin11_val(adc_value) > lin11_val(pk_vin_q))
        pk_vin_q <= adc_value;
      if (adc_step == flrc_pkg::S_TEXT && lin11_val(adc_value) > lin11_val(pk_text_q))
        pk_text_q <= adc_value;
    end
  end

  // readings of the pass in progress
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      {c_vout_q, c_iout_q, c_ichan_q, c_vin_q, c_iin_q} <= '0;
      {c_text_q, c_tint_q, c_svout_q} <= '0;
    end
    else if (adc_valid)
    begin
      case (adc_step)
        flrc_pkg::S_VOUT:  c_vout_q  <= adc_value;
        flrc_pkg::S_IOUT:  c_iout_q  <= adc_value;
        flrc_pkg::S_ICHAN: c_ichan_q <= adc_value;
        flrc_pkg::S_VIN:   c_vin_q   <= adc_value;
        flrc_pkg::S_IIN:   c_iin_q   <= adc_value;
        flrc_pkg::S_SVOUT: c_svout_q <= adc_value[7:0];
        flrc_pkg::S_TEXT:  c_text_q  <= adc_value;
        flrc_pkg::S_TINT:  c_tint_q  <= adc_value;
        default:           c_vout_q  <= c_vout_q;
      endcase
    end
  end

  // page history shifts at each pass end; frozen while a log is held, except in ST_PASS
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NP; i++)
      begin
        p_vout_q[i]  <= '0;
        p_iout_q[i]  <= '0;
        p_ichan_q[i] <= '0;
        p_vin_q[i]   <= '0;
        p_iin_q[i]   <= '0;
        p_svout_q[i] <= '0;
      end
    end
    else if (pass_end && !freeze)
    begin
      for (int i = NP - 1; i > 0; i--)
      begin
        p_vout_q[i]  <= p_vout_q[i-1];
        p_iout_q[i]  <= p_iout_q[i-1];
        p_ichan_q[i] <= p_ichan_q[i-1];
        p_vin_q[i]   <= p_vin_q[i-1];
        p_iin_q[i]   <= p_iin_q[i-1];
        p_svout_q[i] <= p_svout_q[i-1];
      end
      // step 25 itself is not kept: the page takes the values held from earlier steps
      p_vout_q[0]  <= c_vout_q;
      p_iout_q[0]  <= c_iout_q;
      p_ichan_q[0] <= c_ichan_q;
      p_vin_q[0]   <= c_vin_q;
      p_iin_q[0]   <= c_iin_q;
      p_svout_q[0] <= c_svout_q;
    end
  end

  // header snapshot: code and time at the fault, readings when the pass completes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      code_q <= '0;
      snap_time_q <= '0;
      {h_pk_ichan_q, h_pk_vin_q, h_pk_text_q, h_text_q, h_tint_q} <= '0;
    end
    else if (state_q == flrc_pkg::ST_IDLE && new_fault)
    begin
      code_q <= forced_record_store_command ? flrc_pkg::SRC_FORCED : fault_code;
      snap_time_q <= time_q;
    end
    else if (state_q == flrc_pkg::ST_PASS && pass_end)
    begin
      h_pk_ichan_q <= pk_ichan_q;
      h_pk_vin_q   <= pk_vin_q;
      h_text_q     <= c_text_q;
      h_tint_q     <= c_tint_q;
      h_pk_text_q  <= pk_text_q;
    end
  end

  // record byte at a given position
  always_comb
  begin
    int unsigned p;
    int unsigned o;
    p = 0;
    o = 0;
    byte_d = '0;
    if (idx_q < 8'(flrc_pkg::PAGE_BASE))
    begin
      case (idx_q)
        8'(flrc_pkg::B_CODE):         byte_d = code_q;
        8'(flrc_pkg::B_PK_ICHAN):     byte_d = pick(h_pk_ichan_q, 1'b0);
        8'(flrc_pkg::B_PK_ICHAN + 1): byte_d = pick(h_pk_ichan_q, 1'b1);
        8'(flrc_pkg::B_PK_VIN):       byte_d = pick(h_pk_vin_q, 1'b0);
        8'(flrc_pkg::B_PK_VIN + 1):   byte_d = pick(h_pk_vin_q, 1'b1);
        8'(flrc_pkg::B_TEXT):         byte_d = pick(h_text_q, 1'b0);
        8'(flrc_pkg::B_TEXT + 1):     byte_d = pick(h_text_q, 1'b1);
        8'(flrc_pkg::B_TINT):         byte_d = pick(h_tint_q, 1'b0);
        8'(flrc_pkg::B_TINT + 1):     byte_d = pick(h_tint_q, 1'b1);
        8'(flrc_pkg::B_PK_TEXT):      byte_d = pick(h_pk_text_q, 1'b0);
        8'(flrc_pkg::B_PK_TEXT + 1):  byte_d = pick(h_pk_text_q, 1'b1);
        default:
        begin
          if (idx_q >= 8'(flrc_pkg::B_TIME) && idx_q < 8'(flrc_pkg::B_TIME + 6))
            byte_d = snap_time_q[8*(idx_q - 8'(flrc_pkg::B_TIME)) +: 8];
        end
      endcase
    end
    else
    begin
      p = (int'(idx_q) - flrc_pkg::PAGE_BASE) / flrc_pkg::PAGE_LEN;
      o = (int'(idx_q) - flrc_pkg::PAGE_BASE) % flrc_pkg::PAGE_LEN;
      if (p < NP)
      begin
        case (o)
          flrc_pkg::P_VOUT, flrc_pkg::P_VOUT + 1:   byte_d = pick(p_vout_q[p], o[0]);
          flrc_pkg::P_IOUT, flrc_pkg::P_IOUT + 1:   byte_d = pick(p_iout_q[p], o[0]);
          flrc_pkg::P_ICHAN, flrc_pkg::P_ICHAN + 1: byte_d = pick(p_ichan_q[p], o[0]);
          flrc_pkg::P_VIN, flrc_pkg::P_VIN + 1:     byte_d = pick(p_vin_q[p], o[0]);
          flrc_pkg::P_IIN, flrc_pkg::P_IIN + 1:     byte_d = pick(p_iin_q[p], o[0]);
          flrc_pkg::P_SVOUT:                        byte_d = p_svout_q[p];
          default:                                  byte_d = '0;
        endcase
      end
    end
  end

  // a read leads with the block length; idx_q points one past the length
  always_comb
  begin
    send_d    = byte_d;
    send_last = (idx_q == 8'(flrc_pkg::REC_LEN - 1));
    if (state_q == flrc_pkg::ST_READ && !log_present_q)
    begin
      send_d    = flrc_pkg::EMPTY_LEN;
      send_last = 1'b1;
    end
  end

  // sequencer: wait out the pass, save, or answer a read
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= flrc_pkg::ST_IDLE;
      idx_q   <= '0;
    end
    else
    begin
      case (state_q)
        flrc_pkg::ST_IDLE:
        begin
          idx_q <= '0;
          if (new_fault)
            state_q <= flrc_pkg::ST_PASS;
          else if (fault_record_read_command)
            state_q <= flrc_pkg::ST_READ;
        end
        flrc_pkg::ST_PASS:
        begin
          if (pass_end)
            state_q <= flrc_pkg::ST_SAVE;
        end
        flrc_pkg::ST_SAVE, flrc_pkg::ST_READ:
        begin
          // the length slot of a read leaves the record index on byte 0
          if (emit && !len_slot)
          begin
            idx_q <= idx_q + 8'h1;
            if (send_last)
              state_q <= flrc_pkg::ST_IDLE;
          end
        end
        default: state_q <= flrc_pkg::ST_IDLE;
      endcase
    end
  end

  // length byte is sent first after read entry: a read stream is length then record
  always_ff @(posedge clock)
  begin
    if (rst || state_q != flrc_pkg::ST_READ)
      len_sent_q <= 1'b0;
    else if (buf_ready)
      len_sent_q <= 1'b1;
  end

  // log presence; a completed save wins over a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      log_present_q <= 1'b0;
      busy_q        <= 1'b0;
    end
    else
    begin
      busy_q <= (state_q != flrc_pkg::ST_IDLE) || new_fault;
      if (state_q == flrc_pkg::ST_SAVE && emit && send_last)
        log_present_q <= 1'b1;
      else if (record_clear)
        log_present_q <= 1'b0;
    end
  end

  logic       in_v;
  logic [9:0] in_w;
  logic [9:0] out_w;
  always_comb
  begin
    in_v = emit;
    in_w = {state_q == flrc_pkg::ST_SAVE, send_last, send_d};
    if (len_slot)
    begin
      in_w = {2'b00, flrc_pkg::FULL_LEN};
    end
  end

  // the sequencer only advances on accepted record bytes, so a length slot stalls it
  flrc_buf #(.W(10)) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (in_v),
    .in_ready  (buf_ready),
    .in_data   (in_w),
    .out_valid (rec_valid),
    .out_ready (rec_ready),
    .out_data  (out_w)
  );
  assign {rec_to_store, rec_last, rec_data} = out_w;
endmodule

// File: flrc_top_monitor.sv
module flrc_top_monitor #(
  parameter int NP = flrc_pkg::NUM_PAGES
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // capture inputs
  input wire logic       adc_valid,
  input wire logic [4:0] adc_step,
  input wire logic       fault_pulse,
  input wire logic       forced_record_store_command,
  input wire logic       fault_record_read_command,
  // stream and status
  input wire logic       rec_valid,
  input wire logic       rec_ready,
  input wire logic [7:0] rec_data,
  input wire logic       rec_last,
  input wire logic       rec_to_store,
  input wire logic       busy_q,
  input wire logic       log_present_q
);
  logic [7:0] beats_q;
  logic       armed_q;
  wire        acc = rec_valid && rec_ready;
  wire        pend = adc_valid && adc_step == flrc_pkg::LAST_STEP;
  wire        rd = fault_record_read_command && !busy_q;
  // beat index in a stream; a closing beat restarts it
  always_ff @(posedge clock)
  begin
    if (rst || (acc && rec_last))
      beats_q <= 8'h00;
    else if (acc)
      beats_q <= beats_q + 8'h01;
  end
  // a taken capture stays armed until the pass reaches its last step
  always_ff @(posedge clock)
  begin
    if (rst || pend)
      armed_q <= 1'b0;
    else if (!busy_q && (forced_record_store_command || (fault_pulse && !log_present_q)))
      armed_q <= 1'b1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_save_len; acc && rec_to_store |-> rec_last == (beats_q == 8'h92); endproperty
  a_save_len: assert property (p_save_len) else $error("save length wrong");
  property p_hold; rec_valid && !rec_ready |=> rec_valid && $stable(rec_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_wait; rec_valid && rec_to_store |-> !armed_q; endproperty
  a_wait: assert property (p_wait) else $error("save before pass end");
  property p_start; armed_q && pend |-> ##2 rec_valid && rec_to_store; endproperty
  a_start: assert property (p_start) else $error("save late after pass");
  property p_take; !busy_q && fault_pulse && !log_present_q |=> busy_q; endproperty
  a_take: assert property (p_take) else $error("fault not taken");
  property p_empty; rd && !log_present_q |-> ##[1:4] rec_valid && rec_last && rec_data == 8'h00;
  endproperty
  a_empty: assert property (p_empty) else $error("empty reply wrong");
  property p_full; rd && log_present_q |-> ##[1:4] rec_valid && rec_data == 8'h93; endproperty
  a_full: assert property (p_full) else $error("length byte wrong");
  property p_kept; acc && rec_to_store && rec_last |=> log_present_q; endproperty
  a_kept: assert property (p_kept) else $error("log not kept");
  c_save: cover property (acc && rec_to_store && rec_last);
  c_stall: cover property (rec_valid && !rec_ready && rec_to_store);
  c_read: cover property (acc && !rec_to_store && rec_last);
endmodule

// File: test_fault_log_record_capture.sv
`define CHECK(what, want, seen) \
  begin \
    samples_checked++; \
    if ((seen) !== (want)) \
    begin \
      fails++; \
      $display("Error %s expected %h seen %h", what, want, seen); \
    end \
  end

module test_fault_log_record_capture;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NP = flrc_pkg::NUM_PAGES;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        adc_valid = 1'b0;
  logic [4:0]  adc_step = 5'h00;
  logic [15:0] adc_value = 16'h0000;
  logic        fault_pulse = 1'b0;
  logic [7:0]  fault_code = 8'h00;
  logic        forced = 1'b0;
  logic        clear_pk = 1'b0;
  logic        rec_clr = 1'b0;
  logic        rd = 1'b0;
  logic        slow = 1'b0;
  logic        flush = 1'b0;
  logic        rec_valid;
  logic        rec_ready;
  logic [7:0]  rec_data;
  logic        rec_last;
  logic        rec_to_store;
  logic        busy_q;
  logic        log_present_q;
  logic [7:0]  got [0:255];
  int          got_n;
  logic        got_done;
  logic        got_store;
  logic [7:0]  exp_b [0:146];
  int          cyc = 0;
  int          fails = 0;
  int          samples_checked = 0;

  always #25 clock = ~clock;
  // cycles since reset release bound the time stamp
  always @(posedge clock)
    cyc <= rst ? 0 : cyc + 1;

  flrc_top #(.NP(NP)) dut (
    .clock(clock), .rst(rst), .adc_valid(adc_valid), .adc_step(adc_step),
    .adc_value(adc_value), .fault_pulse(fault_pulse), .fault_code(fault_code),
    .forced_record_store_command(forced), .peak_clear_command(clear_pk),
    .record_clear(rec_clr), .fault_record_read_command(rd), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last),
    .rec_to_store(rec_to_store), .busy_q(busy_q), .log_present_q(log_present_q));
  flrc_host_model host (
    .clock(clock), .rst(rst), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_data(rec_data), .rec_last(rec_last), .rec_to_store(rec_to_store), .slow(slow),
    .flush(flush), .got(got), .got_n(got_n), .got_done(got_done), .got_store(got_store));

  // positive linear values with one exponent, so larger k means a larger reading
  function automatic logic [15:0] val(input int s, input int k);
    return 16'hF000 | 16'(s * 16 + k);
  endfunction
  task automatic put(input int i, input logic [15:0] v);
    exp_b[i]     = v[15:8];
    exp_b[i + 1] = v[7:0];
  endtask
  task automatic host_go(input logic s);
    @(posedge clock);
    slow  <= s;
    flush <= 1'b1;
    @(posedge clock);
    flush <= 1'b0;
  endtask
  task automatic read_go();
    host_go(1'b0);
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (got_done !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    if (got_done !== 1'b1)
    begin
      fails++;
      $display("Error stream end expected 1 seen 0");
      tally_and_finish();
    end
    repeat (3) @(posedge clock);
  endtask
  // one multiplexer pass, steps 0 to 25; a fault or forced store rides on step at
  task automatic pass(input int k, input int at, input logic [7:0] code);
    for (int s = 0; s < 26; s++)
    begin
      @(posedge clock);
      adc_valid   <= 1'b1;
      adc_step    <= 5'(s);
      adc_value   <= val(s, k);
      fault_pulse <= (s == at) && (code != 8'hFF);
      forced      <= (s == at) && (code == 8'hFF);
      fault_code  <= code;
    end
    @(posedge clock);
    adc_valid   <= 1'b0;
    fault_pulse <= 1'b0;
    forced      <= 1'b0;
  endtask
  task automatic cmp_rec(input int off);
    for (int i = 0; i < 147; i++)
      if (i == 0 || i > 6)
        `CHECK($sformatf("byte %0d", i), exp_b[i], got[off + i])
  endtask
  task automatic t_empty();
    read_go();
    wait_done();
    `CHECK("empty count", 1, got_n)
    `CHECK("empty byte", 8'h00, got[0])
    $display("test empty read done");
  endtask
  task automatic t_layout();
    int lo;
    int hi;
    @(posedge clock);
    clear_pk <= 1'b1;
    @(posedge clock);
    clear_pk <= 1'b0;
    pass(9, -1, 8'h00);
    repeat (9000) @(posedge clock);
    host_go(1'b1);
    lo = cyc / 4000;
    pass(2, 15, 8'h01);
    wait_done();
    hi = cyc / 4000;
    for (int i = 0; i < 147; i++)
      exp_b[i] = 8'h00;
    exp_b[0] = 8'h01;
    put(13, val(4, 9));
    put(15, val(6, 9));
    put(17, val(12, 2));
    put(21, val(14, 2));
    put(23, val(12, 9));
    // newest page holds the faulted pass, the next page the pass before it
    for (int g = 0; g < 2; g++)
    begin
      for (int j = 0; j < 5; j++)
        put(20 * g + (j == 0 ? 27 : 29 + 2 * j), val(2 * j, g == 0 ? 2 : 9));
      exp_b[39 + 20 * g] = 8'(val(10, g == 0 ? 2 : 9));
    end
    `CHECK("save count", 147, got_n)
    `CHECK("save kind", 1'b1, got_store)
    `CHECK("log kept", 1'b1, log_present_q)
    cmp_rec(0);
    `CHECK("tick", 1'b1, got[1] >= lo && got[1] <= hi)
    for (int i = 2; i < 7; i++)
      `CHECK("tick upper", 8'h00, got[i])
    $display("test capture layout done");
  endtask
  task automatic t_read();
    pass(1, 3, 8'h02);
    `CHECK("busy after refused fault", 1'b0, busy_q)
    read_go();
    wait_done();
    `CHECK("read count", 148, got_n)
    `CHECK("read length", 8'h93, got[0])
    `CHECK("read kind", 1'b0, got_store)
    cmp_rec(1);
    $display("test read back done");
  endtask
  task automatic t_codes();
    logic [7:0] codes [9] = '{8'hFF, 8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0A};
    foreach (codes[c])
    begin
      @(posedge clock);
      rec_clr  <= 1'b1;
      clear_pk <= 1'b1;
      @(posedge clock);
      rec_clr  <= 1'b0;
      clear_pk <= 1'b0;
      host_go(1'b0);
      `CHECK("log cleared", 1'b0, log_present_q)
      pass(1, 20, codes[c]);
      wait_done();
      `CHECK("source code", codes[c], got[0])
      `CHECK("peak since clear", val(4, 1), {got[13], got[14]})
      `CHECK("code count", 147, got_n)
    end
    $display("test source codes done");
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_empty();
    t_layout();
    t_read();
    t_codes();
    tally_and_finish();
  end
endmodule

bind flrc_top flrc_top_monitor #(.NP(NP)) u_mon (
  .clock(clock), .rst(rst), .adc_valid(adc_valid), .adc_step(adc_step),
  .fault_pulse(fault_pulse), .forced_record_store_command(forced_record_store_command),
  .fault_record_read_command(fault_record_read_command), .rec_valid(rec_valid),
  .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last),
  .rec_to_store(rec_to_store), .busy_q(busy_q), .log_present_q(log_present_q));
